//--- hw/cfgld_fetch_if.sv
`timescale 1ns/1ps
interface cfgld_fetch_if;
   logic        start;
   logic        abort;
   logic        legacy;
   logic [31:0] base;
   logic        mem_ack;
   logic [31:0] mem_rdata;
   logic        req;
   logic [31:0] addr;
   logic        byte_valid;
   logic [3:0]  byte_idx;
   logic [7:0]  byte_data;
   logic        done;
   logic [3:0]  count;

   modport ctrl  (output start, abort, legacy, base, mem_ack, mem_rdata,
                  input  req, addr, byte_valid, byte_idx, byte_data,
                         done, count);
   modport fetch (input  start, abort, legacy, base, mem_ack, mem_rdata,
                  output req, addr, byte_valid, byte_idx, byte_data,
                         done, count);
endinterface : cfgld_fetch_if

//--- hw/cfgld_loader.sv
`timescale 1ns/1ps
module cfgld_loader
   import cfgld_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [1:0]  mem_mode,
   input  wire logic        blk_start,
   input  wire logic [31:0] blk_addr,
   input  wire logic        unit_abort,
   output logic             mem_req,
   output logic             mem_we,
   output logic [31:0]      mem_addr,
   output logic [31:0]      mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   output logic             blk_done,
   output logic             blk_aborted,
   output logic             blk_end_of_list,
   output logic             blk_suspend,
   output logic             blk_interrupt,
   output logic             cmd_not_configure,
   output logic             prefetch_mark_en,
   output logic [3:0]       fifo_limit,
   output logic [1:0]       monitor_mode,
   output logic             resume_reread,
   output logic             save_bad_frames,
   output logic [2:0]       address_length,
   output logic             no_source_addr_insert,
   output logic [1:0]       preamble_length,
   output logic [1:0]       loopback_select,
   output logic [2:0]       linear_priority,
   output logic [2:0]       exponential_priority,
   output logic             backoff_method,
   output logic [7:0]       interframe_spacing,
   output logic [10:0]      slot_time,
   output logic [3:0]       retry_limit
);

   typedef enum logic [4:0] {
      S_IDLE    = 5'b00001,
      S_RD_CMD  = 5'b00010,
      S_WR_BUSY = 5'b00100,
      S_FETCH   = 5'b01000,
      S_WR_STAT = 5'b10000
   } cfgld_state_t;

   cfgld_state_t    st_r;
   logic [1:0]      rst_sync_r;
   logic            rst_n_s;
   logic [31:0]     blk_r;
   logic [31:0]     cmd_r;
   logic            abort_r;
   logic [7:0][7:0] shadow_r;
   logic [7:0][7:0] live_r;
   logic [7:0][7:0] nx;
   logic            commit;
   logic            abort_now;
   logic            legacy;
   logic [15:0]     status;

   cfgld_fetch_if fi ();

   cfgld_param_fetch u_fetch (
      .clk   (clk),
      .rst_n (rst_n_s),
      .ce    (ce),
      .fi    (fi)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n_s = rst_sync_r[1];

   assign legacy    = (mem_mode == MODE_LEGACY);
   assign abort_now = unit_abort || abort_r;

   assign commit = (st_r == S_FETCH) && fi.done && !abort_now;

   assign fi.start     = (st_r == S_WR_BUSY) && mem_ack && !abort_now;
   assign fi.abort     = (st_r == S_FETCH) && abort_now;
   assign fi.legacy    = legacy;
   assign fi.base      = blk_r + (legacy ? PARAM_OFS_LEG : PARAM_OFS_NEW);
   assign fi.mem_ack   = (st_r == S_FETCH) && mem_ack;
   assign fi.mem_rdata = mem_rdata;

   always_comb
   begin
      status        = cmd_r[15:0] & 16'h0fff;
      status[ST_B]  = (st_r == S_WR_BUSY);
      status[ST_C]  = (st_r == S_WR_STAT);
      status[ST_OK] = (st_r == S_WR_STAT) && !abort_r;
      status[ST_A]  = (st_r == S_WR_STAT) && abort_r;
   end

   always_comb
   begin
      mem_req   = 1'b0;
      mem_we    = 1'b0;
      mem_addr  = blk_r;
      mem_wdata = {cmd_r[31:16], status};
      case (st_r)
         S_RD_CMD:  mem_req = 1'b1;
         S_WR_BUSY,
         S_WR_STAT:
         begin
            mem_req = 1'b1;
            mem_we  = 1'b1;
         end
         S_FETCH:
         begin
            mem_req  = fi.req;
            mem_addr = fi.addr;
         end
         default:   mem_req = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
         st_r <= S_IDLE;
      else if (ce)
      begin
         case (st_r)
            S_IDLE:    if (blk_start) st_r <= S_RD_CMD;
            S_RD_CMD:
            begin
               if (mem_ack)
                  st_r <= (mem_rdata[CMD_LSB +: 3] == CMD_CONFIGURE) ?
                          S_WR_BUSY : S_IDLE;
            end
            S_WR_BUSY: if (mem_ack) st_r <= abort_now ? S_WR_STAT : S_FETCH;
            S_FETCH:   if (abort_now || fi.done) st_r <= S_WR_STAT;
            S_WR_STAT: if (mem_ack) st_r <= S_IDLE;
            default:   st_r <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         blk_r   <= 32'h0000_0000;
         cmd_r   <= 32'h0000_0000;
         abort_r <= 1'b0;
      end
      else if (ce)
      begin
         if (st_r == S_IDLE && blk_start)
            blk_r <= blk_addr;
         if (st_r == S_RD_CMD && mem_ack)
            cmd_r <= mem_rdata;
         if (st_r == S_IDLE)
            abort_r <= 1'b0;
         else if (unit_abort && st_r != S_RD_CMD && st_r != S_WR_STAT)
            abort_r <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         blk_done          <= 1'b0;
         blk_aborted       <= 1'b0;
         blk_end_of_list   <= 1'b0;
         blk_suspend       <= 1'b0;
         blk_interrupt     <= 1'b0;
         cmd_not_configure <= 1'b0;
      end
      else if (ce)
      begin
         blk_done <= (st_r == S_WR_STAT) && mem_ack;
         cmd_not_configure <= (st_r == S_RD_CMD) && mem_ack &&
                              (mem_rdata[CMD_LSB +: 3] != CMD_CONFIGURE);
         if (st_r == S_WR_STAT && mem_ack)
         begin
            blk_aborted     <= abort_r;
            blk_end_of_list <= cmd_r[FLAG_END_LIST];
            blk_suspend     <= cmd_r[FLAG_S];
            blk_interrupt   <= cmd_r[FLAG_I];
         end
      end
   end

   always_comb
   begin
      nx = live_r;
      for (int k = 0; k < NUM_LIVE; k++)
      begin
         if (4'(k) < fi.count)
            nx[k] = (fi.byte_valid && fi.byte_idx == 4'(k)) ?
                    fi.byte_data : shadow_r[k];
      end
   end

   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         shadow_r <= CFG_RESET;
         live_r   <= CFG_RESET;
      end
      else if (ce)
      begin
         if (fi.byte_valid && fi.byte_idx < 4'(NUM_LIVE))
            shadow_r[fi.byte_idx[2:0]] <= fi.byte_data;
         if (commit)
            live_r <= nx;
      end
   end

   assign prefetch_mark_en      = live_r[0][B0_PREFETCH] && !legacy;
   assign fifo_limit            = live_r[1][B1_FIFO_LSB +: 4];
   assign monitor_mode          = live_r[1][B1_MON_LSB +: 2];
   assign resume_reread         = live_r[2][B2_RESUME_RD];
   assign save_bad_frames       = live_r[2][B2_SAVE_BF];
   assign address_length        = live_r[3][B3_ADDR_LSB +: 3];
   assign no_source_addr_insert = live_r[3][B3_NO_SRC_INS];
   assign preamble_length       = live_r[3][B3_PREAM_LSB +: 2];
   assign loopback_select       = live_r[3][B3_LOOP_LSB +: 2];
   assign linear_priority       = live_r[4][B4_LIN_LSB +: 3];
   assign exponential_priority  = live_r[4][B4_EXP_LSB +: 3];
   assign backoff_method        = live_r[4][B4_BOF];
   assign interframe_spacing    = live_r[5];
   assign slot_time             = {live_r[7][B7_SLOT_LSB +: 3], live_r[6]};
   assign retry_limit           = live_r[7][B7_RETRY_LSB +: 4];

   sequence s_cfg_taken;
      ce && st_r == S_RD_CMD && mem_ack &&
      mem_rdata[CMD_LSB +: 3] == CMD_CONFIGURE;
   endsequence

   sequence s_stat_written;
      ce && st_r == S_WR_STAT && mem_ack;
   endsequence

   a_busy_written: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      s_cfg_taken |=> st_r == S_WR_BUSY && mem_we && mem_wdata[ST_B])
      else $error("busy status not written after configure decode");

   a_other_cmd_idle: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      ce && st_r == S_RD_CMD && mem_ack &&
      mem_rdata[CMD_LSB +: 3] != CMD_CONFIGURE
      |=> st_r == S_IDLE && cmd_not_configure)
      else $error("non-configure command not rejected");

   a_abort_status: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      s_stat_written |-> mem_wdata[ST_A] == abort_r &&
                         mem_wdata[ST_OK] == !abort_r && mem_wdata[ST_C])
      else $error("aborted and ok bits wrong in final status");

   a_done_follows: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      s_stat_written |=> blk_done ##1 (!blk_done || !$past(ce)))
      else $error("done pulse missing after status write");

   a_no_early_apply: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      !commit |=> $stable(live_r))
      else $error("configuration changed before fetch completed");

   a_fifo_threshold: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      ce && commit && fi.count > 4'h1 |=> fifo_limit == $past(nx[1][3:0]))
      else $error("FIFO threshold not taken from byte 1");

   a_slot_assemble: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      ce && commit |=> slot_time == {$past(nx[7][2:0]), $past(nx[6])})
      else $error("slot time not formed from bytes 6 and 7");

   a_short_keeps_slot: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      ce && commit && fi.count <= 4'h6 |=> $stable(slot_time))
      else $error("unreached slot time changed");

   a_legacy_no_mark: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      legacy |-> !prefetch_mark_en)
      else $error("prefetch mark enabled in legacy mode");

   a_loopback_field: assert property (
      @(posedge clk) disable iff (!rst_n_s)
      ce && commit && fi.count > 4'h3 |=>
      loopback_select == $past(nx[3][7:6]) &&
      address_length == $past(nx[3][2:0]))
      else $error("byte 3 fields decoded wrongly");

endmodule : cfgld_loader

//--- hw/cfgld_param_fetch.sv
`timescale 1ns/1ps
module cfgld_param_fetch
   import cfgld_pkg::*;
(
   input wire logic   clk,
   input wire logic   rst_n,
   input wire logic   ce,
   cfgld_fetch_if.fetch fi
);

   typedef enum logic [1:0] {F_IDLE = 2'b01, F_READ = 2'b10} cfgld_fst_t;

   cfgld_fst_t  st_r;
   logic [3:0]  idx_r;
   logic [3:0]  count_r;
   logic [7:0]  data_r;
   logic [3:0]  bidx_r;
   logic        bvalid_r;
   logic        done_r;
   logic [31:0] baddr;
   logic [7:0]  cur;
   logic [3:0]  lim;
   logic        take;
   logic        last;

   assign baddr = fi.base + {28'h0000000, idx_r};
   assign cur   = lane_byte(fi.mem_rdata, baddr[1:0]);
   assign take  = (st_r == F_READ) && fi.mem_ack && !fi.abort;
   assign lim   = (idx_r == 4'h0) ? clamp_count(cur[3:0], fi.legacy)
                                  : count_r;
   assign last  = (4'(idx_r + 4'h1) == lim);

   assign fi.req        = (st_r == F_READ) && !fi.abort;
   assign fi.addr       = {baddr[31:2], 2'b00};
   assign fi.byte_valid = bvalid_r;
   assign fi.byte_idx   = bidx_r;
   assign fi.byte_data  = data_r;
   assign fi.done       = done_r;
   assign fi.count      = count_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= F_IDLE;
      else if (ce)
      begin
         case (st_r)
            F_IDLE:  if (fi.start) st_r <= F_READ;
            F_READ:  if (fi.abort || (take && last)) st_r <= F_IDLE;
            default: st_r <= F_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idx_r   <= 4'h0;
         count_r <= 4'h0;
      end
      else if (ce)
      begin
         if (fi.start && st_r == F_IDLE)
            idx_r <= 4'h0;
         else if (take)
            idx_r <= 4'(idx_r + 4'h1);
         if (take && idx_r == 4'h0)
            count_r <= lim;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bvalid_r <= 1'b0;
         done_r   <= 1'b0;
         data_r   <= 8'h00;
         bidx_r   <= 4'h0;
      end
      else if (ce)
      begin
         bvalid_r <= take;
         done_r   <= take && last;
         if (take)
         begin
            data_r <= cur;
            bidx_r <= idx_r;
         end
      end
   end

   a_byte_index_cap: assert property (
      @(posedge clk) disable iff (!rst_n)
      bvalid_r |-> (bidx_r < CNT_MAX_NEW))
      else $error("parameter byte index beyond fourteen");

   a_legacy_min_count: assert property (
      @(posedge clk) disable iff (!rst_n)
      ce && take && idx_r == 4'h0 && fi.legacy |=> count_r >= CNT_MIN_LEG)
      else $error("legacy byte count below four");

endmodule : cfgld_param_fetch

//--- hw/cfgld_pkg.sv
package cfgld_pkg;

   // Command word layout
   localparam int          CMD_LSB        = 16;
   localparam logic [2:0]  CMD_CONFIGURE  = 3'h2;
   localparam int          FLAG_END_LIST  = 31;
   localparam int          FLAG_S         = 30;
   localparam int          FLAG_I         = 29;
   localparam int          ST_C           = 15;
   localparam int          ST_B           = 14;
   localparam int          ST_OK          = 13;
   localparam int          ST_A           = 12;

   // Memory modes
   localparam logic [1:0]  MODE_LEGACY    = 2'h0;
   localparam logic [1:0]  MODE_SEGMENTED = 2'h1;
   localparam logic [1:0]  MODE_LINEAR    = 2'h2;

   // Byte offsets inside the block: first parameter byte, and link word
   localparam logic [31:0] PARAM_OFS_LEG  = 32'h0000_0006;
   localparam logic [31:0] PARAM_OFS_NEW  = 32'h0000_0008;
   localparam logic [31:0] LINK_WORD_OFS  = 32'h0000_0004;

   // Byte count limits
   localparam logic [3:0]  CNT_MAX_NEW    = 4'he;
   localparam logic [3:0]  CNT_MIN_NEW    = 4'h1;
   localparam logic [3:0]  CNT_MAX_LEG    = 4'hc;
   localparam logic [3:0]  CNT_MIN_LEG    = 4'h4;

   localparam int          NUM_LIVE       = 8;

   // Values after reset, byte 7 down to byte 0
   localparam logic [7:0][7:0] CFG_RESET  = {8'hf2, 8'h00, 8'h60, 8'h00,
                                             8'h26, 8'h40, 8'hc8, 8'h00};

   // Field positions
   localparam int          B0_PREFETCH    = 7;
   localparam int          B1_FIFO_LSB    = 0;
   localparam int          B1_MON_LSB     = 6;
   localparam int          B2_RESUME_RD   = 1;
   localparam int          B2_SAVE_BF     = 7;
   localparam int          B3_ADDR_LSB    = 0;
   localparam int          B3_NO_SRC_INS  = 3;
   localparam int          B3_PREAM_LSB   = 4;
   localparam int          B3_LOOP_LSB    = 6;
   localparam int          B4_LIN_LSB     = 0;
   localparam int          B4_EXP_LSB     = 4;
   localparam int          B4_BOF         = 7;
   localparam int          B7_SLOT_LSB    = 0;
   localparam int          B7_RETRY_LSB   = 4;

   function automatic logic [7:0] lane_byte(input logic [31:0] w,
                                            input logic [1:0]  lane);
      lane_byte = w[{lane, 3'b000} +: 8];
   endfunction : lane_byte

   function automatic logic [3:0] clamp_count(input logic [3:0] n,
                                              input logic       legacy);
      if (legacy)
      begin
         clamp_count = (n < CNT_MIN_LEG) ? CNT_MIN_LEG :
                       (n > CNT_MAX_LEG) ? CNT_MAX_LEG : n;
      end
      else
      begin
         clamp_count = (n < CNT_MIN_NEW) ? CNT_MIN_NEW :
                       (n > CNT_MAX_NEW) ? CNT_MAX_NEW : n;
      end
   endfunction : clamp_count

endpackage : cfgld_pkg

//--- verification/cfgld_host_mem.sv
`timescale 1ns/1ps
module cfgld_host_mem
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [3:0]  delay,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ack,
   output logic [31:0]      mem_rdata,
   output int               busy_cnt
);
   logic [31:0] mem [0:63];
   logic [3:0]  wait_r;
   logic [31:0] last_r;
   logic        pend;

   initial busy_cnt = 0;

   assign pend = mem_req && !mem_ack;

   // One-cycle answer after delay waiting cycles
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_ack <= 1'b0;
         wait_r  <= 4'h0;
      end
      else
      begin
         mem_ack <= pend && (wait_r >= delay);
         wait_r  <= (pend && wait_r < delay) ? wait_r + 4'h1 : 4'h0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (mem_ack && !mem_we)
         last_r <= mem_rdata;
   end

   // Released data lines show the inverse of the last word
   assign mem_rdata = mem_ack ? mem[mem_addr[7:2]] : ~last_r;

   always @(posedge clk)
   begin
      if (ce && mem_req && mem_ack && mem_we)
      begin
         mem[mem_addr[7:2]] <= mem_wdata;
         busy_cnt           <= busy_cnt + int'(mem_wdata[14]);
      end
   end
endmodule : cfgld_host_mem

//--- verification/cfgld_loader_test.sv
`timescale 1ns/1ps
module cfgld_loader_test
   import cfgld_pkg::*;
();
   typedef struct packed {
      logic [1:0]      mode;
      logic [3:0]      dly;
      logic [2:0]      flg;
      logic            stall;
      logic [7:0][7:0] b;
   } cfgld_row_t;

   localparam logic [31:0]     BASE = 32'h0000_0040;
   localparam logic [7:0][7:0] DEF  = 64'hf200_6000_2640_c800;
   localparam logic [7:0][7:0] SOME = 64'h1111_1111_1111_1188;
   localparam cfgld_row_t ROWS [6] = '{
      '{MODE_LINEAR,    4'h0, 3'h5, 1'b0, 64'h35a7_3cb5_d982_4588},
      '{MODE_SEGMENTED, 4'h2, 3'h2, 1'b1, 64'h1111_1111_1102_0a83},
      '{MODE_LEGACY,    4'h1, 3'h0, 1'b0, 64'h6e5d_4c3b_7f81_1382},
      '{MODE_LINEAR,    4'h0, 3'h4, 1'b0, 64'h0000_0000_0000_0080},
      '{MODE_SEGMENTED, 4'h3, 3'h1, 1'b0, 64'hf7ff_0012_c682_4f8f},
      '{MODE_LINEAR,    4'h1, 3'h7, 1'b0, 64'h0a12_3456_789a_bc87}};

   logic            clk, rst_n, ce, blk_start, unit_abort;
   logic [1:0]      mem_mode;
   logic [3:0]      dly, fifo_limit, retry_limit;
   logic [31:0]     blk_addr, mem_addr, mem_wdata, mem_rdata;
   logic            mem_req, mem_we, mem_ack, blk_done, blk_aborted;
   logic            blk_end_of_list, blk_suspend, blk_interrupt;
   logic            cmd_not_configure, prefetch_mark_en, resume_reread;
   logic            save_bad_frames, no_source_addr_insert, backoff_method;
   logic [1:0]      monitor_mode, preamble_length, loopback_select;
   logic [2:0]      address_length, linear_priority, exponential_priority;
   logic [7:0]      interframe_spacing;
   logic [10:0]     slot_time;
   int              busy_cnt, err_total, checks_done;
   logic [7:0][7:0] cur;

   cfgld_loader cfgld_loader_i (.clk, .rst_n, .ce, .mem_mode, .blk_start,
      .blk_addr, .unit_abort, .mem_req, .mem_we, .mem_addr, .mem_wdata,
      .mem_ack, .mem_rdata, .blk_done, .blk_aborted, .blk_end_of_list,
      .blk_suspend, .blk_interrupt, .cmd_not_configure, .prefetch_mark_en,
      .fifo_limit, .monitor_mode, .resume_reread, .save_bad_frames,
      .address_length, .no_source_addr_insert, .preamble_length,
      .loopback_select, .linear_priority, .exponential_priority,
      .backoff_method, .interframe_spacing, .slot_time, .retry_limit);

   cfgld_host_mem cfgld_host_mem_i (.clk, .rst_n, .ce, .delay(dly),
      .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
      .busy_cnt);

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   function automatic int eff(input logic [1:0] m, input logic [3:0] n);
      if (m == MODE_LEGACY)
         return (n < 4) ? 4 : (n > 12) ? 12 : int'(n);
      return (n == 0) ? 1 : (n > 14) ? 14 : int'(n);
   endfunction : eff

   task automatic check_cfg(input logic [1:0] m);
      check("prefetch", 32'(prefetch_mark_en),
            32'(cur[0][7] && m != MODE_LEGACY));
      check("fifo", 32'({monitor_mode, fifo_limit}),
            32'({cur[1][7:6], cur[1][3:0]}));
      check("resume", 32'(resume_reread), 32'(cur[2][1]));
      check("badframes", 32'(save_bad_frames), 32'(cur[2][7]));
      check("byte3", 32'({loopback_select, preamble_length,
            no_source_addr_insert, address_length}), 32'(cur[3]));
      check("byte4", 32'({backoff_method, exponential_priority,
            linear_priority}), 32'({cur[4][7:4], cur[4][2:0]}));
      check("spacing", 32'(interframe_spacing), 32'(cur[5]));
      check("slot", 32'(slot_time), 32'({cur[7][2:0], cur[6]}));
      check("retry", 32'(retry_limit), 32'(cur[7][7:4]));
   endtask : check_cfg

   task automatic run(input logic [1:0] m, input logic [3:0] d,
                      input logic [2:0] f, input logic [2:0] code,
                      input logic st, input logic ab,
                      input logic [7:0][7:0] b);
      logic [31:0] a;
      logic [31:0] ofs;
      logic        hit, armed, got_d, got_n;
      int          bc;
      ofs   = (m == MODE_LEGACY) ? 32'h6 : 32'h8;
      bc    = busy_cnt;
      hit   = 1'b0;
      armed = 1'b0;
      got_d = 1'b0;
      got_n = 1'b0;
      for (int k = 0; k < 8; k++)
         cfgld_host_mem_i.mem[16+k] = 32'h0;
      // command code with reserved bits zero
      cfgld_host_mem_i.mem[16] = {f, 10'h000, code, 16'h0123};
      for (int k = 0; k < 14; k++)
      begin
         a = BASE + ofs + 32'(k);
         cfgld_host_mem_i.mem[a[7:2]][8*a[1:0] +: 8] = (k < 8) ? b[k] : 8'h5a;
      end
      @(posedge clk);
      mem_mode <= m;
      dly      <= d;
      @(posedge clk);
      blk_start <= 1'b1;
      blk_addr  <= BASE;
      @(posedge clk);
      blk_start <= 1'b0;
      for (int n = 0; n < 400 && !(got_d || got_n); n++)
      begin
         @(posedge clk);
         ce       <= !(st && n >= 4 && n < 7);
         unit_abort <= hit;
         hit = 1'b0;
         #1;
         if (ab && !armed && mem_req === 1'b1 && mem_addr === BASE + 32'h8)
         begin
            hit   = 1'b1;
            armed = 1'b1;
         end
         got_d = (blk_done === 1'b1);
         got_n = (cmd_not_configure === 1'b1);
      end
      if (!(got_d || got_n))
      begin
         err_total++;
         $display("unexpected wait: expected done, seen timeout");
         test_done();
      end
      check("outcome", 32'({got_d, got_n}),
            (code == 3'h2) ? 32'h2 : 32'h1);
      if (code == 3'h2 && !ab)
      begin
         for (int k = 0; k < 8; k++)
            if (k < eff(m, b[0][3:0]))
               cur[k] = b[k];
      end
      check_cfg(m);
      check("status", cfgld_host_mem_i.mem[16], (code != 3'h2) ?
            {f, 10'h000, code, 16'h0123} :
            {f, 10'h000, code, ab ? 4'h9 : 4'ha, 12'h123});
      if (code == 3'h2)
      begin
         check("aborted", 32'(blk_aborted), 32'(ab));
         check("flags", 32'({blk_end_of_list, blk_suspend, blk_interrupt}),
               32'(f));
         check("busy", busy_cnt - bc, 32'h1);
      end
   endtask : run

   initial
   begin
      rst_n       = 1'b0;
      ce          = 1'b1;
      blk_start   = 1'b0;
      unit_abort  = 1'b0;
      blk_addr    = 32'h0;
      mem_mode    = MODE_LINEAR;
      dly         = 4'h0;
      err_total   = 0;
      checks_done = 0;
      cur         = DEF;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (ROWS[i])
         run(ROWS[i].mode, ROWS[i].dly, ROWS[i].flg, 3'h2, ROWS[i].stall,
             1'b0, ROWS[i].b);
      // Abort in mid-fetch, then a clean run clears the flag
      run(MODE_LINEAR, 4'h3, 3'h0, 3'h2, 1'b0, 1'b1, SOME);
      run(MODE_LINEAR, 4'h0, 3'h0, 3'h2, 1'b0, 1'b0, SOME);
      for (int c = 0; c < 8; c++)
         if (c != 2)
            run(MODE_SEGMENTED, 4'h0, 3'h0, 3'(c), 1'b0, 1'b0, SOME);
      // Reset in mid-run restores the defaults
      cfgld_host_mem_i.mem[16] = {16'h0002, 16'h0000};
      @(posedge clk);
      blk_start <= 1'b1;
      @(posedge clk);
      blk_start <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      cur = DEF;
      check_cfg(MODE_LINEAR);
      check("aborted", 32'(blk_aborted), 32'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      run(ROWS[0].mode, 4'h1, 3'h3, 3'h2, 1'b0, 1'b0, ROWS[0].b);
      test_done();
   end
endmodule : cfgld_loader_test
